//--- bpp_pkg.sv
// package for the bidirectional port pin logic
package bpp_pkg;
    localparam int P23_W = 8;
    localparam int P4_W = 4;
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam logic [3:0] LATCH4_RST = 4'hf;
    localparam logic [7:0] PULLUP_RST = 8'hff;
    localparam logic [3:0] PULLUP4_RST = 4'hf;
    localparam int BOOST_CYCLES = 2;
    localparam logic [1:0] BOOST_LOAD = 2'h2;
    localparam int PIN_WR = 6;
    localparam int PIN_RD = 7;
    localparam int PIN_IRQ0 = 2;

    // cpu side write request for one port
    typedef struct packed {
        logic byte_we;
        logic bit_we;
        logic [2:0] bit_sel;
        logic bit_val;
        logic [7:0] wdata;
    } bpp_wr_t;

    // pad drive for an 8-bit port
    typedef struct packed {
        logic [7:0] strong_lo;
        logic [7:0] strong_hi;
        logic [7:0] weak_hi;
    } bpp_drv8_t;

    typedef struct packed {
        logic [3:0] strong_lo;
        logic [3:0] strong_hi;
        logic [3:0] weak_hi;
    } bpp_drv4_t;

    typedef enum logic [1:0] {
        BPP_ADDR_LATCH = 2'b00,
        BPP_ADDR_FULL = 2'b01,
        BPP_ADDR_SHORT = 2'b10
    } bpp_addr_t;
endpackage

//--- bpp_top.sv
// port 2/3/4 latch, drive sequencing and pin read logic
`timescale 1ns/100ps
module bpp_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic romless_i,
    input wire logic program_store_strobe_n_i,
    input wire logic ext_access_i,
    input wire bpp_pkg::bpp_addr_t addr_mode_i,
    input wire logic [7:0] addr_high_i,
    input wire logic wr_strobe_used_i,
    input wire logic wr_strobe_n_i,
    input wire logic rd_strobe_n_i,
    input wire logic ext_irq0_en_i,
    input wire logic [7:0] port3_alt_out_i,
    input wire logic [7:0] port3_alt_en_i,
    input wire bpp_pkg::bpp_wr_t port2_wr_i,
    input wire bpp_pkg::bpp_wr_t port3_wr_i,
    input wire bpp_pkg::bpp_wr_t port4_wr_i,
    input wire logic [7:0] port2_pullup_select_i,
    input wire logic [7:0] port3_pullup_select_i,
    input wire logic [3:0] port4_pullup_select_i,
    input wire logic rmw_read_i,
    input wire logic [7:0] port2_pin_i,
    input wire logic [7:0] port3_pin_i,
    input wire logic [3:0] port4_pin_i,
    output logic [7:0] port2_rdata_o,
    output logic [7:0] port3_rdata_o,
    output logic [3:0] port4_rdata_o,
    output bpp_pkg::bpp_drv8_t port2_drv_o,
    output bpp_pkg::bpp_drv8_t port3_drv_o,
    output bpp_pkg::bpp_drv4_t port4_drv_o,
    output logic ext_irq0_n_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] p2_s1;
        logic [7:0] p2_s2;
        logic [7:0] p3_s1;
        logic [7:0] p3_s2;
        logic [3:0] p4_s1;
        logic [3:0] p4_s2;
        logic [1:0] program_store_strobe_n_sync;
        logic program_store_strobe_n_prev;
        logic romless_hold;
        logic [7:0] port2_latch;
        logic [7:0] port3_latch;
        logic [3:0] port4_latch;
        logic [7:0] p2_eff_prev;
        logic [7:0] p3_eff_prev;
        logic [3:0] p4_eff_prev;
        logic [7:0][1:0] p2_boost;
        logic [7:0][1:0] p3_boost;
        logic [3:0][1:0] p4_boost;
        logic [7:0] port2_rdata;
        logic [7:0] port3_rdata;
        logic [3:0] port4_rdata;
        bpp_pkg::bpp_drv8_t p2_drv;
        bpp_pkg::bpp_drv8_t p3_drv;
        bpp_pkg::bpp_drv4_t p4_drv;
        logic irq0_n;
    } bpp_state_t;

    bpp_state_t s_q;
    bpp_state_t s_d;
    logic rst_n;
    logic [1:0] rst_ff_q;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_ff_q <= 2'h0;
        else
            rst_ff_q <= {rst_ff_q[0], 1'b1};
    end
    assign rst_n = rst_ff_q[1];

    // byte write wins over a bit write landing in the same cycle
    function automatic logic [7:0] apply_wr(input logic [7:0] cur, input bpp_pkg::bpp_wr_t w);
        logic [7:0] r;
        r = cur;
        if (w.byte_we)
            r = w.wdata;
        else if (w.bit_we)
            r[w.bit_sel] = w.bit_val;
        return r;
    endfunction

    logic [7:0] p2_eff;
    logic [7:0] p3_eff;
    logic [3:0] p4_eff;
    logic program_store_strobe_n_rise;
    logic [7:0] tmp4;

    always_comb
    begin
        s_d = s_q;
        tmp4 = 8'h00;
        // pin inputs pass two flops before use
        s_d.p2_s1 = port2_pin_i;
        s_d.p2_s2 = s_q.p2_s1;
        s_d.p3_s1 = port3_pin_i;
        s_d.p3_s2 = s_q.p3_s1;
        s_d.p4_s1 = port4_pin_i;
        s_d.p4_s2 = s_q.p4_s1;
        s_d.program_store_strobe_n_sync = {s_q.program_store_strobe_n_sync[0], program_store_strobe_n_i};
        s_d.program_store_strobe_n_prev = s_q.program_store_strobe_n_sync[1];
        program_store_strobe_n_rise = s_q.program_store_strobe_n_sync[1] && !s_q.program_store_strobe_n_prev;

        // bit writes merge into the full byte, then store it
        s_d.port2_latch = apply_wr(s_q.port2_latch, port2_wr_i);
        s_d.port3_latch = apply_wr(s_q.port3_latch, port3_wr_i);
        tmp4 = apply_wr({4'h0, s_q.port4_latch}, port4_wr_i);
        s_d.port4_latch = tmp4[3:0];
        // a full-address access leaves the address in the latch
        if (ext_access_i && addr_mode_i == bpp_pkg::BPP_ADDR_FULL)
            s_d.port2_latch = addr_high_i;

        // romless part: strong drive latched after program strobe rises
        if (!romless_i)
            s_d.romless_hold = 1'b0;
        else if (program_store_strobe_n_rise)
            s_d.romless_hold = 1'b1;

        // port2 effective output value
        p2_eff = s_q.port2_latch;
        if (ext_access_i && addr_mode_i == bpp_pkg::BPP_ADDR_FULL)
            p2_eff = addr_high_i;
        else if (ext_access_i && addr_mode_i == bpp_pkg::BPP_ADDR_SHORT)
            p2_eff = s_q.port2_latch;

        // port3 alternate outputs gated by latch
        p3_eff = s_q.port3_latch;
        for (int i = 0; i < bpp_pkg::P23_W; i++)
        begin
            if (port3_alt_en_i[i])
                p3_eff[i] = s_q.port3_latch[i] & port3_alt_out_i[i];
        end
        // read strobe idles high, so pin 7 acts as plain i/o between accesses
        // strobes take pins 7 and 6; pin 6 stays i/o if write unused
        p3_eff[bpp_pkg::PIN_RD] = s_q.port3_latch[bpp_pkg::PIN_RD] & rd_strobe_n_i;
        if (wr_strobe_used_i)
            p3_eff[bpp_pkg::PIN_WR] = s_q.port3_latch[bpp_pkg::PIN_WR] & wr_strobe_n_i;
        p4_eff = s_q.port4_latch;
        s_d.p2_eff_prev = p2_eff;
        s_d.p3_eff_prev = p3_eff;
        s_d.p4_eff_prev = p4_eff;

        // drive sequencing: low strong, boost two cycles, then weak
        for (int i = 0; i < bpp_pkg::P23_W; i++)
        begin
            // rising edge loads the boost counter
            if (p2_eff[i] && !s_q.p2_eff_prev[i])
                s_d.p2_boost[i] = bpp_pkg::BOOST_LOAD;
            else if (!p2_eff[i])
                s_d.p2_boost[i] = 2'h0;
            else if (s_q.p2_boost[i] != 2'h0)
                s_d.p2_boost[i] = s_q.p2_boost[i] - 2'h1;
            if (p3_eff[i] && !s_q.p3_eff_prev[i])
                s_d.p3_boost[i] = bpp_pkg::BOOST_LOAD;
            else if (!p3_eff[i])
                s_d.p3_boost[i] = 2'h0;
            else if (s_q.p3_boost[i] != 2'h0)
                s_d.p3_boost[i] = s_q.p3_boost[i] - 2'h1;
        end
        for (int i = 0; i < bpp_pkg::P4_W; i++)
        begin
            if (p4_eff[i] && !s_q.p4_eff_prev[i])
                s_d.p4_boost[i] = bpp_pkg::BOOST_LOAD;
            else if (!p4_eff[i])
                s_d.p4_boost[i] = 2'h0;
            else if (s_q.p4_boost[i] != 2'h0)
                s_d.p4_boost[i] = s_q.p4_boost[i] - 2'h1;
        end
        for (int i = 0; i < bpp_pkg::P23_W; i++)
        begin
            s_d.p2_drv.strong_lo[i] = !p2_eff[i];
            s_d.p2_drv.strong_hi[i] = (p2_eff[i] && s_d.p2_boost[i] != 2'h0)
                || (s_d.romless_hold && p2_eff[i]);
            // weak hold as on ports one to four; port zero float not built
            // weak hold only where the select bit enables it
            s_d.p2_drv.weak_hi[i] = p2_eff[i] && port2_pullup_select_i[i]
                && !s_d.p2_drv.strong_hi[i];
            s_d.p3_drv.strong_lo[i] = !p3_eff[i];
            s_d.p3_drv.strong_hi[i] = p3_eff[i] && s_d.p3_boost[i] != 2'h0;
            s_d.p3_drv.weak_hi[i] = p3_eff[i] && port3_pullup_select_i[i]
                && !s_d.p3_drv.strong_hi[i];
        end
        for (int i = 0; i < bpp_pkg::P4_W; i++)
        begin
            s_d.p4_drv.strong_lo[i] = !p4_eff[i];
            s_d.p4_drv.strong_hi[i] = p4_eff[i] && s_d.p4_boost[i] != 2'h0;
            s_d.p4_drv.weak_hi[i] = p4_eff[i] && port4_pullup_select_i[i]
                && !s_d.p4_drv.strong_hi[i];
        end

        // reads: latch for read-modify-write, pins otherwise
        s_d.port2_rdata = rmw_read_i ? s_q.port2_latch : s_q.p2_s2;
        s_d.port3_rdata = rmw_read_i ? s_q.port3_latch : s_q.p3_s2;
        s_d.port4_rdata = rmw_read_i ? s_q.port4_latch : s_q.p4_s2;

        // irq0 from pin 2 only when enabled and latch high
        s_d.irq0_n = !(ext_irq0_en_i && s_q.port3_latch[bpp_pkg::PIN_IRQ0]
            && !s_q.p3_s2[bpp_pkg::PIN_IRQ0]);
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // latches come up at one so every pin wakes as an input, weak-held only where its select bit is set
            s_q <= '0;
            s_q.port2_latch <= bpp_pkg::LATCH_RST;
            s_q.port3_latch <= bpp_pkg::LATCH_RST;
            s_q.port4_latch <= bpp_pkg::LATCH4_RST;
            s_q.p2_eff_prev <= bpp_pkg::LATCH_RST;
            s_q.p3_eff_prev <= bpp_pkg::LATCH_RST;
            s_q.p4_eff_prev <= bpp_pkg::LATCH4_RST;
            s_q.program_store_strobe_n_sync <= 2'h3;
            s_q.program_store_strobe_n_prev <= 1'b1;
            s_q.irq0_n <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // outputs, straight from the state flops
    // ------------------------------------------------------------
    assign port2_rdata_o = s_q.port2_rdata;
    assign port3_rdata_o = s_q.port3_rdata;
    assign port4_rdata_o = s_q.port4_rdata;
    assign port2_drv_o = s_q.p2_drv;
    assign port3_drv_o = s_q.p3_drv;
    assign port4_drv_o = s_q.p4_drv;
    assign ext_irq0_n_o = s_q.irq0_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a rising strong drive on port2 pin 0 lasts two cycles unless the latch bit drops
    boost_len_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        $rose(s_q.p2_drv.strong_hi[0]) && !s_q.romless_hold |=>
        s_q.p2_drv.strong_hi[0] ##1 !s_q.p2_drv.strong_hi[0] || !s_q.port2_latch[0])
        else $error("boost not two cycles");
    low_strong_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !s_q.port4_latch[0] |=> s_q.p4_drv.strong_lo[0])
        else $error("pull-down missing");
    weak_sel_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !port3_pullup_select_i[1] |=> !s_q.p3_drv.weak_hi[1])
        else $error("weak pull-up while deselected");
    rmw_read_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        rmw_read_i |=> port3_rdata_o == $past(s_q.port3_latch))
        else $error("rmw read not latch");
    pin_read_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !rmw_read_i |=> port2_rdata_o == $past(s_q.p2_s2))
        else $error("pin read wrong");
    irq_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !ext_irq0_en_i |=> ext_irq0_n_o)
        else $error("irq0 while disabled");
    alt_block_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !s_q.port3_latch[bpp_pkg::PIN_RD] |=> s_q.p3_drv.strong_lo[bpp_pkg::PIN_RD])
        else $error("alternate not blocked");
    bit_write_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        port3_wr_i.bit_we && !port3_wr_i.byte_we |=>
        s_q.port3_latch[$past(port3_wr_i.bit_sel)] == $past(port3_wr_i.bit_val))
        else $error("bit write lost");

    // external access and romless drive
    full_addr_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        ext_access_i && addr_mode_i == bpp_pkg::BPP_ADDR_FULL |=>
        s_q.p2_drv.strong_lo == ~$past(addr_high_i))
        else $error("high address not driven");
    short_addr_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        ext_access_i && addr_mode_i == bpp_pkg::BPP_ADDR_SHORT |=>
        s_q.p2_drv.strong_lo == ~$past(s_q.port2_latch))
        else $error("short access not latch");
    latch_overwrite_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        ext_access_i && addr_mode_i == bpp_pkg::BPP_ADDR_FULL |=>
        s_q.port2_latch == $past(addr_high_i))
        else $error("latch not overwritten");
    romless_drive_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        s_q.romless_hold && romless_i |=> s_q.p2_drv.strong_hi == $past(p2_eff))
        else $error("romless drive not strong");

    // port three strobes, alternates and interrupt
    rd_strobe_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !rd_strobe_n_i |=> s_q.p3_drv.strong_lo[bpp_pkg::PIN_RD])
        else $error("read strobe not on pin");
    wr_pin_io_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !wr_strobe_used_i && s_q.port3_latch[bpp_pkg::PIN_WR]
        && !port3_alt_en_i[bpp_pkg::PIN_WR] |=> !s_q.p3_drv.strong_lo[bpp_pkg::PIN_WR])
        else $error("unused write strobe on pin");
    alt_out_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        port3_alt_en_i[0] && !port3_alt_out_i[0] |=> s_q.p3_drv.strong_lo[0])
        else $error("alternate low not driven");
    irq_fire_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        ext_irq0_en_i && s_q.port3_latch[bpp_pkg::PIN_IRQ0]
        && !s_q.p3_s2[bpp_pkg::PIN_IRQ0] |=> !ext_irq0_n_o)
        else $error("irq0 not raised");

    // pull-ups, writes and reads
    p2_pullup_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !port2_pullup_select_i[0] |=> !s_q.p2_drv.weak_hi[0])
        else $error("port2 pull-up not off");
    p4_pullup_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !port4_pullup_select_i[1] |=> !s_q.p4_drv.weak_hi[1])
        else $error("port4 pull-up not off");
    byte_write_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        port4_wr_i.byte_we |=> s_q.port4_latch == $past(port4_wr_i.wdata[3:0]))
        else $error("byte write lost");
    rmw4_read_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        rmw_read_i |=> port4_rdata_o == $past(s_q.port4_latch))
        else $error("port4 rmw read not latch");
    pin3_read_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        !rmw_read_i |=> port3_rdata_o == $past(s_q.p3_s2))
        else $error("port3 pin read wrong");
endmodule // bpp_top

//--- bpp_pin_mdl.sv
// pin-side model: external drivers and pads on one port
`timescale 1ns/100ps
module bpp_pin_mdl #(
    parameter int W = 8
) (
    input wire logic clock_i,
    input wire logic [W-1:0] lo_i,
    input wire logic [W-1:0] hi_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] pin_o
);
    // -----------------
    // pad level
    // -----------------
    // an undriven pad flips every cycle, so a stale value never passes
    logic [W-1:0] churn_q = '0;
    always_ff @(posedge clock_i)
    begin
        churn_q <= ~churn_q;
    end
    // outside source only where no strong low is driven on the pad, never fighting a pull-down
    assign pin_o = (~lo_i & ext_en_i & ext_val_i)
        | (~lo_i & ~ext_en_i & (hi_i | churn_q));
endmodule // bpp_pin_mdl

//--- tb.sv
// self-checking bench for the port pin logic
`timescale 1ns/100ps
module tb;
    logic clk = 0, rst_n = 0, rmw = 0, irq_en = 0, ext = 0;
    logic romless = 0, program_store_strobe_n_n = 1, wr_used = 0, wr_n = 1, rd_n = 1;
    logic [7:0] alt_out = 8'hff, alt_en = 8'h00;
    bpp_pkg::bpp_addr_t mode = bpp_pkg::BPP_ADDR_LATCH;
    logic [7:0] ah = 8'h00, s2 = 8'h3c, s3 = 8'hfd, e2 = 8'h00, e3 = 8'h00;
    logic [3:0] s4 = 4'h5;
    bpp_pkg::bpp_wr_t w2 = '0, w3 = '0, w4 = '0;
    bpp_pkg::bpp_drv8_t d2, d3;
    bpp_pkg::bpp_drv4_t d4;
    logic [7:0] p2, p3, r2, r3;
    logic [3:0] p4, r4;
    logic irq;
    int fails = 0, comparisons = 0, ticks = 0, n;
    initial
    begin
        forever #4 clk = ~clk;
    end
    bpp_top bpp_top_inst (.clock_i(clk), .rst_n_i(rst_n), .romless_i(romless),
        .program_store_strobe_n_i(program_store_strobe_n_n), .ext_access_i(ext), .addr_mode_i(mode),
        .addr_high_i(ah), .wr_strobe_used_i(wr_used), .wr_strobe_n_i(wr_n),
        .rd_strobe_n_i(rd_n), .ext_irq0_en_i(irq_en), .port3_alt_out_i(alt_out),
        .port3_alt_en_i(alt_en), .port2_wr_i(w2), .port3_wr_i(w3), .port4_wr_i(w4),
        .port2_pullup_select_i(s2), .port3_pullup_select_i(s3),
        .port4_pullup_select_i(s4), .rmw_read_i(rmw), .port2_pin_i(p2),
        .port3_pin_i(p3), .port4_pin_i(p4), .port2_rdata_o(r2), .port3_rdata_o(r3),
        .port4_rdata_o(r4), .port2_drv_o(d2), .port3_drv_o(d3), .port4_drv_o(d4),
        .ext_irq0_n_o(irq));
    bpp_pin_mdl #(.W(8)) m2_inst (.clock_i(clk), .lo_i(d2.strong_lo),
        .hi_i(d2.strong_hi | d2.weak_hi), .ext_en_i(e2), .ext_val_i(8'h00), .pin_o(p2));
    bpp_pin_mdl #(.W(8)) m3_inst (.clock_i(clk), .lo_i(d3.strong_lo),
        .hi_i(d3.strong_hi | d3.weak_hi), .ext_en_i(e3), .ext_val_i(8'h00), .pin_o(p3));
    bpp_pin_mdl #(.W(4)) m4_inst (.clock_i(clk), .lo_i(d4.strong_lo),
        .hi_i(d4.strong_hi | d4.weak_hi), .ext_en_i(4'h0), .ext_val_i(4'h0), .pin_o(p4));
    // -----------------
    // shared tasks
    // -----------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write pulse, then a quiet cycle so pulses never merge
    task automatic pw(input int p, input logic bw, input logic [2:0] s, input logic [7:0] d);
        bpp_pkg::bpp_wr_t w;
        w = '{byte_we: ~bw, bit_we: bw, bit_sel: s, bit_val: d[0], wdata: d};
        if (p == 2)
            w2 = w;
        else if (p == 3)
            w3 = w;
        else
            w4 = w;
        cyc(1);
        w2 = '0;
        w3 = '0;
        w4 = '0;
        cyc(1);
    endtask
    task automatic end_of_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // -----------------
    // scenarios
    // -----------------
    task automatic t_pullup();
        chk(d2.weak_hi, s2);
        chk(d2.strong_lo, 8'h00);
        chk({4'h0, d4.weak_hi}, {4'h0, s4});
        chk(d3.weak_hi, s3);
        s2 = 8'hff;
        s3 = 8'hff;
    endtask
    task automatic t_boost();
        pw(4, 0, 0, 8'h00);
        cyc(3);
        chk({4'h0, d4.strong_lo}, 8'h0f);
        pw(4, 0, 0, 8'h01);
        n = 0;
        repeat (7)
        begin
            n += d4.strong_hi[0];
            cyc(1);
        end
        chk(8'(n), 8'h02);
        chk({7'h0, d4.weak_hi[0]}, 8'h01);
    endtask
    task automatic t_read();
        pw(2, 1, 3, 8'h00);
        e2 = 8'h20;
        e3 = 8'h10;
        rmw = 1;
        cyc(4);
        chk(r2, 8'hf7);
        chk(r3, 8'hff);
        chk({4'h0, r4}, 8'h01);
        rmw = 0;
        cyc(4);
        chk(r2, 8'hd7);
        chk(r3, 8'hef);
        e2 = 8'h00;
        e3 = 8'h00;
    endtask
    task automatic t_addr();
        ah = 8'ha5;
        mode = bpp_pkg::BPP_ADDR_FULL;
        ext = 1;
        cyc(2);
        chk(d2.strong_lo, 8'h5a);
        ext = 0;
        rmw = 1;
        cyc(4);
        chk(r2, 8'ha5);
        ah = 8'h3c;
        mode = bpp_pkg::BPP_ADDR_SHORT;
        ext = 1;
        cyc(2);
        chk(d2.strong_lo, 8'h5a);
        ext = 0;
        cyc(4);
        chk(r2, 8'ha5);
        rmw = 0;
    endtask
    task automatic t_romless();
        romless = 1;
        program_store_strobe_n_n = 0;
        cyc(3);
        chk(d2.strong_hi, 8'h00);
        program_store_strobe_n_n = 1;
        cyc(5);
        chk(d2.strong_hi, 8'ha5);
        chk(d2.weak_hi, 8'h00);
        romless = 0;
        cyc(2);
        chk(d2.strong_hi, 8'h00);
    endtask
    task automatic t_alt();
        rd_n = 0;
        wr_n = 0;
        cyc(2);
        chk(d3.strong_lo, 8'h80);
        wr_used = 1;
        cyc(2);
        chk(d3.strong_lo, 8'hc0);
        rd_n = 1;
        wr_n = 1;
        wr_used = 0;
        alt_en = 8'h01;
        alt_out = 8'h00;
        cyc(2);
        chk(d3.strong_lo, 8'h01);
        alt_out = 8'h01;
        pw(3, 1, 0, 8'h00);
        chk(d3.strong_lo, 8'h01);
        alt_en = 8'h00;
        alt_out = 8'hff;
        pw(3, 1, 0, 8'h01);
        chk(d3.strong_hi, 8'h01);
    endtask
    task automatic t_irq();
        irq_en = 1;
        e3 = 8'h04;
        cyc(5);
        chk({7'h0, irq}, 8'h00);
        irq_en = 0;
        cyc(5);
        chk({7'h0, irq}, 8'h01);
        irq_en = 1;
        e3 = 8'h00;
        pw(3, 1, 2, 8'h00);
        cyc(5);
        chk({7'h0, irq}, 8'h01);
    endtask
    // -----------------
    // main sequence and hang guard
    // -----------------
    always @(posedge clk)
    begin
        ticks++;
        if (ticks > 2000)
        begin
            fails++;
            end_of_test();
        end
    end
    initial
    begin
        cyc(10);
        rst_n = 1;
        cyc(4);
        t_pullup();
        t_boost();
        t_read();
        t_addr();
        t_romless();
        t_alt();
        t_irq();
        end_of_test();
    end
endmodule // tb
